//--- rtl/sleep_id_regs.sv
// Purpose: Sleep routing mask, die identifier and chip identity registers
// Assumes: APB slave, two-cycle access phase (one wait state), 16-bit data in low bits
// Notes:   Unmapped addresses read zero and answer with pslverr
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Sleep pin reaches a block only when its mask bit is one.
// - Mask bits 15..12 gate channel A, channel B, fuse block, temperature sensor.
// - Bits 11..7 gate sample clock, data, sync, alignment, data clock receivers.
// - Mask bits 6..0 are reserved and route sleep nowhere.
// - Mask at 0x15 resets to all ones.
// - Die identifier bits 15..0 read only at 0x16.
// - Die identifier bits 31..16 at 0x17, 47..32 at 0x18.
// - Die identifier bits 63..48 read only at 0x19.
// - Identity register 0x7F bit 6 always reads one.
// - Identity register bit 5 always reads zero.
module sleep_id_regs (
    input  wire logic        clock,               // 100 MHz clock
    input  wire logic        rst,                 // Async reset, active high
    input  wire logic        psel,                // APB select
    input  wire logic        penable,             // APB enable
    input  wire logic        pwrite,              // APB write
    input  wire logic [9:0]  paddr,               // APB byte address
    input  wire logic [31:0] pwdata,              // APB write data
    input  wire logic [3:0]  pstrb,               // APB byte strobes
    output var  logic [31:0] prdata,              // APB read data
    output var  logic        pready,              // APB ready
    output var  logic        pslverr,             // APB error
    input  wire logic [63:0] die_identifier_bits, // Fused die identifier
    input  wire logic        sleep_pin,           // External sleep pin
    output var  logic        sleep_channel_a,     // Sleep to channel A
    output var  logic        sleep_channel_b,     // Sleep to channel B
    output var  logic        sleep_fuse,          // Sleep to fuse block
    output var  logic        sleep_temp_sensor,   // Sleep to temp sensor
    output var  logic        sleep_clock_rx,      // Sleep to sample clock rx
    output var  logic        sleep_data_rx,       // Sleep to data receivers
    output var  logic        sleep_sync_rx,       // Sleep to sync receiver
    output var  logic        sleep_alignment_receiver,   // Sleep to align rx
    output var  logic        sleep_data_clock_receiver   // Sleep to dclk rx
);
    logic [15:0] sleep_mask_reg;
    logic        sleep_sync;
    logic        access;
    logic        addr_ok;
    logic [7:0]  index;
    logic [15:0] read_next;
    logic        known;
    logic [15:0] chip_id;
    logic [8:0]  gate_next;
    logic [8:0]  gate_reg;

    // Pin is asynchronous, so it crosses two flops first
    level_sync pin_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in (sleep_pin),
        .sync_out (sleep_sync)
    );

    // Decode word index; low address bits must be zero
    assign access  = psel && penable && !pready;
    assign addr_ok = (paddr[1:0] == 2'h0);
    assign index   = paddr[9:2];

    // Fixed identity word
    assign chip_id = {9'h000, 1'b1, 1'b0, sleep_id_pkg::MAKER_CODE,
                      sleep_id_pkg::REVISION_CODE};

    // Read mux and address check
    always_comb begin
        read_next = 16'h0000;
        known     = addr_ok;
        case (index)
            sleep_id_pkg::SLEEP_MASK_IDX: read_next = sleep_mask_reg;
            sleep_id_pkg::DIE_WORD0_IDX:
                read_next = die_identifier_bits[15:0];
            sleep_id_pkg::DIE_WORD1_IDX:
                read_next = die_identifier_bits[31:16];
            sleep_id_pkg::DIE_WORD2_IDX:
                read_next = die_identifier_bits[47:32];
            sleep_id_pkg::DIE_WORD3_IDX:
                read_next = die_identifier_bits[63:48];
            sleep_id_pkg::CHIP_ID_IDX:   read_next = chip_id;
            default:                     known     = 1'b0;
        endcase
        if (!addr_ok) begin
            read_next = 16'h0000;
        end
    end

    // APB handshake: ready one cycle after the access phase starts
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access;
            pslverr <= access && !known;
            if (access && !pwrite) begin
                prdata <= {16'h0000, read_next};
            end else if (access) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Only the mask is writable; identifier writes fall through
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sleep_mask_reg <= sleep_id_pkg::SLEEP_MASK_RESET;
        end else if (access && pwrite && addr_ok &&
                     index == sleep_id_pkg::SLEEP_MASK_IDX) begin
            if (pstrb[0]) begin
                sleep_mask_reg[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                sleep_mask_reg[15:8] <= pwdata[15:8];
            end
        end
    end

    // Only bits 15..7 gate a block; low bits are stored but unused
    assign gate_next = sleep_sync ?
        sleep_mask_reg[15:sleep_id_pkg::SLEEP_FIRST_BIT] : 9'h000;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gate_reg <= 9'h000;
        end else begin
            gate_reg <= gate_next;
        end
    end

    // Bit order from the top of the mask downward
    assign sleep_channel_a           = gate_reg[8];
    assign sleep_channel_b           = gate_reg[7];
    assign sleep_fuse                = gate_reg[6];
    assign sleep_temp_sensor         = gate_reg[5];
    assign sleep_clock_rx            = gate_reg[4];
    assign sleep_data_rx             = gate_reg[3];
    assign sleep_sync_rx             = gate_reg[2];
    assign sleep_alignment_receiver  = gate_reg[1];
    assign sleep_data_clock_receiver = gate_reg[0];
endmodule : sleep_id_regs
`default_nettype wire

//--- common/sleep_id_pkg.sv
// Purpose: Shared constants for the sleep routing and die identity registers
// Assumes: APB with 32-bit data, registers as 16-bit words in the low bits
// Notes:   Printed offsets are word indices; byte address is index times four
package sleep_id_pkg;
    // Register indices as printed
    localparam logic [7:0]  SLEEP_MASK_IDX   = 8'h15;
    localparam logic [7:0]  DIE_WORD0_IDX    = 8'h16;
    localparam logic [7:0]  DIE_WORD1_IDX    = 8'h17;
    localparam logic [7:0]  DIE_WORD2_IDX    = 8'h18;
    localparam logic [7:0]  DIE_WORD3_IDX    = 8'h19;
    localparam logic [7:0]  CHIP_ID_IDX      = 8'h7F;
    localparam int          ADDR_WIDTH       = 10;
    // Reset and field values
    localparam logic [15:0] SLEEP_MASK_RESET = 16'hFFFF;
    localparam int          SLEEP_FIRST_BIT  = 7;
    localparam int          SLEEP_TARGETS    = 9;
    localparam int          VOH_BIT          = 6;
    localparam int          VOL_BIT          = 5;
    localparam int          MAKER_LSB        = 3;
    localparam int          REVISION_LSB     = 0;
    // Arbitrary neutral identity codes
    localparam logic [1:0]  MAKER_CODE       = 2'h2;
    localparam logic [2:0]  REVISION_CODE    = 3'h5;
    // Arbitrary die identifier; no register logic refers to it
    localparam logic [63:0] DIE_ID_DEFAULT   = 64'h0123_4567_89AB_CDEF;
    localparam int          SYNC_STAGES      = 2;
endpackage : sleep_id_pkg

//--- rtl/level_sync.sv
// Purpose: Two-stage synchroniser for one asynchronous level
// Assumes: Input changes slowly compared with the clock
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module level_sync (
    input  wire logic clock,     // System clock
    input  wire logic rst,       // Asynchronous reset, active high
    input  wire logic async_in,  // Level from outside the domain
    output var  logic sync_out   // Synchronised level
);
    logic meta_reg;

    // Only sync_out is read by other logic
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : level_sync
`default_nettype wire

//--- verification/sleep_id_regs_props.sv
// Purpose: Port assertions for the sleep and identity registers
// Assumes: APB answer after one wait state, registered read data
// Notes:   Sleep outputs lag the pin by three edges
`timescale 1ns/1ps
`default_nettype none
module sleep_id_regs_props (
    input wire logic        clock,                    // Clock
    input wire logic        rst,                      // Reset
    input wire logic        psel,                     // Select
    input wire logic        penable,                  // Enable
    input wire logic        pwrite,                   // Write
    input wire logic [9:0]  paddr,                    // Address
    input wire logic [31:0] prdata,                   // Read data
    input wire logic        pready,                   // Ready
    input wire logic        pslverr,                  // Error
    input wire logic [63:0] die_identifier_bits,      // Die id
    input wire logic        sleep_pin,                // Pin
    input wire logic        sleep_channel_a,          // Channel A
    input wire logic        sleep_data_clock_receiver // Dclk rx
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Access phase waiting, pin held low long enough to pass the sync
    sequence s_access; psel && penable && !pready; endsequence
    sequence s_pin_low; !sleep_pin [*4]; endsequence
    sequence s_rd(a); pready && !pwrite && paddr == a; endsequence
    // Bus timing, register contents, then sleep outputs
    a_ready_wait: assert property (s_access |=> pready) else $error("late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("long");
    a_err_ready: assert property (pslverr |-> pready) else $error("err");
    a_unmapped_err: assert property (s_rd(10'h100) |-> pslverr
        && prdata == 32'h0) else $error("unmapped");
    a_ident_value: assert property (s_rd(10'h1FC) |->
        prdata == 32'h0000_0055) else $error("ident");
    a_die_low: assert property (s_rd(10'h058) |->
        prdata[15:0] == die_identifier_bits[15:0]) else $error("die0");
    a_die_top: assert property (s_rd(10'h064) |->
        prdata[15:0] == die_identifier_bits[63:48]) else $error("die3");
    a_write_zero: assert property (pready && pwrite |->
        prdata == 32'h0) else $error("wdata");
    a_sleep_quiet: assert property (s_pin_low |->
        !sleep_channel_a && !sleep_data_clock_receiver) else $error("slp");
endmodule : sleep_id_regs_props
`default_nettype wire

//--- verification/sleep_id_regs_test.sv
// Purpose: APB register and sleep routing tests
// Assumes: Ready comes after one wait state
// Notes:   Die identifier input held at a fixed pattern
`timescale 1ns/1ps
`default_nettype none
`define CHK(g,e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module sleep_id_regs_test;
    logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        sleep_pin = 0, pready, pslverr, rerr;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [8:0]  sv;
    logic [63:0] die_id = 64'hFEDC_BA98_7654_3210;
    int          error_cnt = 0, cmp_count = 0;
    always #5 clock = ~clock;
    sleep_id_regs i_dut (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .die_identifier_bits(die_id), .sleep_pin(sleep_pin),
        .sleep_channel_a(sv[8]), .sleep_channel_b(sv[7]),
        .sleep_fuse(sv[6]), .sleep_temp_sensor(sv[5]),
        .sleep_clock_rx(sv[4]), .sleep_data_rx(sv[3]),
        .sleep_sync_rx(sv[2]), .sleep_alignment_receiver(sv[1]),
        .sleep_data_clock_receiver(sv[0]));
    // One transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [9:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // A slave that never answers counts as a mismatch
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, pready, 1'b1);
        end
        {rdat, rerr} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : xfer
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask : rd
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        tally_and_finish();
    end
    // Reset values, read-only words, routing, then refusals
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rd(10'h054, 32'h0000_FFFF);
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 4; i++) begin
                xfer(1'b1, 10'h058 + 10'(4 * i), 32'h0000_A5A5);
                rd(10'h058 + 10'(4 * i), {16'h0, die_id[16 * i +: 16]});
            end
            xfer(1'b1, 10'h1FC, 32'h0000_FFFF);
            rd(10'h1FC, 32'h0000_0055);
        end
        $display("test read only done");
        // Reserved bits stay set so any leak of them would show
        for (int i = 0; i < 10; i++) begin
            xfer(1'b1, 10'h054, 32'h0000_007F | (32'h0000_8000 >> i));
            sleep_pin <= 1'b1;
            repeat (4) @(posedge clock);
            `CHK(sv, 9'h100 >> i)
            sleep_pin <= 1'b0;
            repeat (4) @(posedge clock);
            `CHK(sv, 9'h000)
        end
        rd(10'h054, 32'h0000_007F);
        $display("test sleep routing done");
        rd(10'h100, 32'h0);
        `CHK(rerr, 1'b1)
        rd(10'h056, 32'h0);
        `CHK(rerr, 1'b1)
        $display("test refusals done");
        tally_and_finish();
    end
endmodule : sleep_id_regs_test
bind sleep_id_regs sleep_id_regs_props u_props (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .die_identifier_bits(die_identifier_bits), .sleep_pin(sleep_pin),
    .sleep_channel_a(sleep_channel_a),
    .sleep_data_clock_receiver(sleep_data_clock_receiver));
`default_nettype wire
